// ---- verilog/dca_defines.svh ----
// constants for the command/address capture and data-phase block
// assumes inclusion by bare name from every design file that needs them
`ifndef DCA_DEFINES_SVH
`define DCA_DEFINES_SVH

// command/address edge counts
`define DCA_CA_LAST_EDGE   3'd5
`define DCA_ROW_LAST_EDGE  3'd3

// command/address field positions
`define DCA_BIT_READ       47
`define DCA_BIT_SPACE      46
`define DCA_BIT_LINEAR     45
`define DCA_ROW_HI         44
`define DCA_ROW_LO         16
`define DCA_COL_HI         2
`define DCA_COL_LO         0

// reset values and the unmasked write byte enable
`define DCA_CA_RST         48'h000000000000
`define DCA_WORD_RST       16'h0000
`define DCA_ADDR_RST       32'h00000000
`define DCA_ROW_RST        29'h00000000
`define DCA_MASK_NONE      2'b11

`endif

// ---- verilog/dca_pkg.sv ----
// types shared by the command/address capture block
// assumes nothing of its surroundings
`default_nettype none

package dca_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_BAD,
    ST_RD_LAT,
    ST_RD_DATA,
    ST_WR_LAT,
    ST_WR_DATA
  } dca_state_t;

endpackage

`default_nettype wire

// ---- verilog/dca_edge.sv ----
// level sampler with rise and fall pulses
// assumes the level is synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module dca_edge #(
  parameter logic RST_LEVEL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic level_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle level of the pin, so no false edge follows reset
      level_r <= RST_LEVEL;
    end else begin
      level_r <= level;
    end
  end

  assign rise = level & ~level_r;
  assign fall = ~level & level_r;

endmodule // dca_edge

`default_nettype wire

// ---- verilog/dca_fifo2.sv ----
// small first-in first-out buffer with valid/ready on both sides
// assumes one clock; flush drops every stored word
`timescale 1ns/1ps
`default_nettype none

module dca_fifo2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != CW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end

endmodule // dca_fifo2

`default_nettype wire

// ---- verilog/dca_decode_x16.sv ----
// command/address capture, decode and data phase of a x16 ddr memory port
// assumes bus pins are sampled by MCLK fast enough to see every bus clock edge;
// latency counting lives outside and reports the data phase by DATA_START
`timescale 1ns/1ps
`default_nettype none
`include "dca_defines.svh"

module dca_decode_x16 #(
  parameter int RD_DEPTH = 2
) (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        CS_N,
  input  wire logic        BUS_CLOCK_TRUE,
  input  wire logic        BUS_CLOCK_COMPLEMENT,
  input  wire logic [15:0] DQ_IN,
  output logic      [15:0] DQ_OUT,
  output logic             DQ_OE,
  input  wire logic [1:0]  RW_DATA_STROBE_IN,
  output logic      [1:0]  RW_DATA_STROBE_OUT,
  output logic      [1:0]  RW_DATA_STROBE_OE,
  input  wire logic        LATENCY_EXTRA,
  input  wire logic        ZERO_LATENCY_WRITE,
  input  wire logic        DATA_START,
  output logic             START_ERROR,
  output logic             ROW_VALID,
  output logic      [28:0] ROW_ADDR,
  output logic             ROW_READ,
  output logic             CMD_VALID,
  output logic             CMD_READ,
  output logic             CMD_REG_SPACE,
  output logic             CMD_LINEAR,
  output logic      [31:0] CMD_WORD_ADDR,
  output logic             BURST_END,
  output logic      [31:0] BEAT_ADDR,
  output logic             BEAT_SECOND,
  input  wire logic [15:0] RD_DATA,
  input  wire logic        RD_VALID,
  output logic             RD_READY,
  output logic             RD_UNDERRUN,
  output logic      [15:0] WR_DATA,
  output logic      [1:0]  WR_BYTE_EN,
  output logic             WR_VALID
);

  dca_pkg::dca_state_t state_r;
  dca_pkg::dca_state_t state_nxt;

  logic        ck_rise;
  logic        ck_fall;
  logic        ck_edge;
  logic        cs_rise;
  logic        cs_fall;
  logic        clock_idle;
  logic [2:0]  edge_cnt_r;
  logic [47:0] ca_r;
  logic [47:0] ca_nxt;
  logic        lat_r;
  logic        zero_lat_r;
  logic [31:0] addr_r;
  logic [15:0] buf_data;
  logic        buf_valid;
  logic        buf_pop;
  logic        buf_in_ready;

  dca_edge u_ck_edge (
    .clk   (MCLK),
    .rst_n (RESETN),
    .level (BUS_CLOCK_TRUE),
    .rise  (ck_rise),
    .fall  (ck_fall)
  );

  dca_edge #(
    .RST_LEVEL (1'b1)
  ) u_cs_edge (
    .clk   (MCLK),
    .rst_n (RESETN),
    .level (CS_N),
    .rise  (cs_rise),
    .fall  (cs_fall)
  );

  assign ck_edge    = ck_rise | ck_fall;
  assign clock_idle = ~BUS_CLOCK_TRUE & BUS_CLOCK_COMPLEMENT;
  // upper lines never enter the shift, whatever the host drives there
  assign ca_nxt     = {ca_r[39:0], DQ_IN[7:0]};

  // read words wait here so a late bus edge never drops one
  dca_fifo2 #(
    .WIDTH (16),
    .DEPTH (RD_DEPTH)
  ) u_rd_buf (
    .clk       (MCLK),
    .rst_n     (RESETN),
    .flush     (CS_N),
    .in_data   (RD_DATA),
    .in_valid  (RD_VALID),
    .in_ready  (buf_in_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop)
  );

  assign RD_READY = buf_in_ready & ~CS_N;
  assign buf_pop  = (state_r == dca_pkg::ST_RD_DATA) & ck_edge;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dca_pkg::ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = clock_idle ? dca_pkg::ST_CMD : dca_pkg::ST_BAD;
        end
      end
      dca_pkg::ST_CMD: begin
        if (ck_edge && edge_cnt_r == `DCA_CA_LAST_EDGE) begin
          state_nxt = ca_nxt[`DCA_BIT_READ] ? dca_pkg::ST_RD_LAT : dca_pkg::ST_WR_LAT;
        end
      end
      dca_pkg::ST_BAD: begin
        state_nxt = dca_pkg::ST_BAD;
      end
      dca_pkg::ST_RD_LAT: begin
        if (DATA_START) begin
          state_nxt = dca_pkg::ST_RD_DATA;
        end
      end
      dca_pkg::ST_RD_DATA: begin
        state_nxt = dca_pkg::ST_RD_DATA;
      end
      dca_pkg::ST_WR_LAT: begin
        if (DATA_START) begin
          state_nxt = dca_pkg::ST_WR_DATA;
        end
      end
      dca_pkg::ST_WR_DATA: begin
        state_nxt = dca_pkg::ST_WR_DATA;
      end
    endcase
    // select high ends any burst, checked last so it wins
    if (CS_N) begin
      state_nxt = dca_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= dca_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // command shift and edge count
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ca_r       <= `DCA_CA_RST;
      edge_cnt_r <= 3'd0;
    end else if (state_r == dca_pkg::ST_IDLE) begin
      edge_cnt_r <= 3'd0;
    end else if (state_r == dca_pkg::ST_CMD && ck_edge) begin
      ca_r       <= ca_nxt;
      edge_cnt_r <= edge_cnt_r + 3'd1;
    end
  end

  // latency hint and write mode, held for the whole transaction
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      lat_r      <= 1'b0;
      zero_lat_r <= 1'b0;
    end else if (state_r == dca_pkg::ST_IDLE && cs_fall) begin
      lat_r      <= LATENCY_EXTRA;
      zero_lat_r <= ZERO_LATENCY_WRITE;
    end
  end

  // early row pulse lets the array start before the start word arrives
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ROW_VALID <= 1'b0;
      ROW_ADDR  <= `DCA_ROW_RST;
      ROW_READ  <= 1'b0;
    end else begin
      ROW_VALID <= 1'b0;
      if (state_r == dca_pkg::ST_CMD && ck_edge && edge_cnt_r == `DCA_ROW_LAST_EDGE) begin
        ROW_VALID <= 1'b1;
        ROW_ADDR  <= ca_nxt[28:0];
        ROW_READ  <= ca_nxt[31];
      end
    end
  end

  // decoded command, one pulse after the sixth edge
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      CMD_VALID     <= 1'b0;
      CMD_READ      <= 1'b0;
      CMD_REG_SPACE <= 1'b0;
      CMD_LINEAR    <= 1'b0;
      CMD_WORD_ADDR <= `DCA_ADDR_RST;
    end else begin
      CMD_VALID <= 1'b0;
      if (state_r == dca_pkg::ST_CMD && ck_edge && edge_cnt_r == `DCA_CA_LAST_EDGE) begin
        CMD_VALID     <= 1'b1;
        CMD_READ      <= ca_nxt[`DCA_BIT_READ];
        CMD_REG_SPACE <= ca_nxt[`DCA_BIT_SPACE];
        CMD_LINEAR    <= ca_nxt[`DCA_BIT_LINEAR];
        // reserved bits 15..3 are dropped here
        CMD_WORD_ADDR <= {ca_nxt[`DCA_ROW_HI:`DCA_ROW_LO],
                          ca_nxt[`DCA_COL_HI:`DCA_COL_LO]};
      end
    end
  end

  // beat address: one step per bus cycle, after its second word
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_r      <= `DCA_ADDR_RST;
      BEAT_ADDR   <= `DCA_ADDR_RST;
      BEAT_SECOND <= 1'b0;
    end else if (CMD_VALID) begin
      addr_r <= CMD_WORD_ADDR;
    end else if ((state_r == dca_pkg::ST_RD_DATA || state_r == dca_pkg::ST_WR_DATA)
                 && ck_edge) begin
      BEAT_ADDR   <= addr_r;
      BEAT_SECOND <= ck_fall;
      if (ck_fall) begin
        addr_r <= addr_r + 32'd1;
      end
    end
  end

  // strobe pins: latency hint, then read strobe, released for writes
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      RW_DATA_STROBE_OUT <= 2'b00;
      RW_DATA_STROBE_OE  <= 2'b00;
    end else begin
      unique case (state_nxt)
        dca_pkg::ST_CMD: begin
          // lat_r still holds the previous hint in the first command cycle
          RW_DATA_STROBE_OUT <= {2{(state_r == dca_pkg::ST_IDLE) ? LATENCY_EXTRA : lat_r}};
          RW_DATA_STROBE_OE  <= 2'b11;
        end
        dca_pkg::ST_RD_LAT: begin
          RW_DATA_STROBE_OUT <= 2'b00;
          RW_DATA_STROBE_OE  <= 2'b11;
        end
        dca_pkg::ST_RD_DATA: begin
          if (state_r == dca_pkg::ST_RD_DATA && ck_edge) begin
            RW_DATA_STROBE_OUT <= {2{ck_rise}};
          end
          RW_DATA_STROBE_OE <= 2'b11;
        end
        default: begin
          // write phases leave the strobe to the host or undriven
          RW_DATA_STROBE_OUT <= 2'b00;
          RW_DATA_STROBE_OE  <= 2'b00;
        end
      endcase
    end
  end

  // read data leaves with the strobe transition that carries it
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      DQ_OUT      <= `DCA_WORD_RST;
      DQ_OE       <= 1'b0;
      RD_UNDERRUN <= 1'b0;
    end else begin
      RD_UNDERRUN <= 1'b0;
      DQ_OE       <= (state_nxt == dca_pkg::ST_RD_DATA);
      if (buf_pop) begin
        if (buf_valid) begin
          DQ_OUT <= buf_data;
        end else begin
          RD_UNDERRUN <= 1'b1;
        end
      end
    end
  end

  // write words sampled on each bus edge, with their byte masks except in zero latency write mode
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      WR_DATA    <= `DCA_WORD_RST;
      WR_BYTE_EN <= 2'b00;
      WR_VALID   <= 1'b0;
    end else begin
      WR_VALID <= 1'b0;
      if (state_r == dca_pkg::ST_WR_DATA && ck_edge) begin
        WR_VALID   <= 1'b1;
        WR_DATA    <= DQ_IN;
        WR_BYTE_EN <= zero_lat_r ? `DCA_MASK_NONE : ~RW_DATA_STROBE_IN;
      end
    end
  end

  // status pulses
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      START_ERROR <= 1'b0;
      BURST_END   <= 1'b0;
    end else begin
      START_ERROR <= (state_r == dca_pkg::ST_IDLE) & cs_fall & ~clock_idle;
      BURST_END   <= cs_rise & (state_r != dca_pkg::ST_IDLE);
    end
  end

endmodule // dca_decode_x16

`default_nettype wire

// ---- verification/dca_decode_x16_asserts.sv ----
// concurrent checks on the command/address decoder ports
// assumes one clock, MCLK, and the asynchronous active-low RESETN
`timescale 1ns/1ps
`default_nettype none

module dca_decode_x16_asserts #(
  parameter int RD_DEPTH = 2
) (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        CS_N,
  input wire logic        BUS_CLOCK_TRUE,
  input wire logic        BUS_CLOCK_COMPLEMENT,
  input wire logic        LATENCY_EXTRA,
  input wire logic        ZERO_LATENCY_WRITE,
  input wire logic        DQ_OE,
  input wire logic [1:0]  RW_DATA_STROBE_OUT,
  input wire logic [1:0]  RW_DATA_STROBE_OE,
  input wire logic        START_ERROR,
  input wire logic        ROW_VALID,
  input wire logic [28:0] ROW_ADDR,
  input wire logic        ROW_READ,
  input wire logic        CMD_VALID,
  input wire logic        CMD_READ,
  input wire logic [31:0] CMD_WORD_ADDR,
  input wire logic        BURST_END,
  input wire logic        WR_VALID,
  input wire logic [1:0]  WR_BYTE_EN
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  // row capture must precede the full command within one selection
  logic row_seen_r;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      row_seen_r <= 1'b0;
    end else if (CS_N || CMD_VALID) begin
      row_seen_r <= 1'b0;
    end else if (ROW_VALID) begin
      row_seen_r <= 1'b1;
    end
  end

  AST_START_CHECK: assert property ($fell(CS_N) |=> START_ERROR == $past(BUS_CLOCK_TRUE))
    else $error("start refusal does not follow bus clock state");
  AST_STROBE_CMD: assert property (
    $fell(CS_N) && !BUS_CLOCK_TRUE && BUS_CLOCK_COMPLEMENT
    |=> RW_DATA_STROBE_OE == 2'b11 && RW_DATA_STROBE_OUT == {2{$past(LATENCY_EXTRA)}})
    else $error("strobe not showing latency in command phase");
  AST_CMD_ROW: assert property (CMD_VALID |-> CMD_WORD_ADDR[31:3] == ROW_ADDR
    && CMD_READ == ROW_READ && row_seen_r)
    else $error("command fields disagree with row capture");
  AST_CMD_PULSE: assert property (CMD_VALID |=> !CMD_VALID)
    else $error("command valid longer than one cycle");
  AST_ZLW_UNMASKED: assert property (
    WR_VALID && ZERO_LATENCY_WRITE |-> WR_BYTE_EN == 2'b11)
    else $error("zero latency write was masked");
  AST_WR_UNDRIVEN: assert property (WR_VALID |-> !DQ_OE && RW_DATA_STROBE_OE == 2'b00)
    else $error("device drives pins during write data");
  AST_RD_STROBE: assert property (DQ_OE |-> RW_DATA_STROBE_OE == 2'b11)
    else $error("read data without driven strobe");
  AST_BURST_END: assert property ($rose(CS_N) && DQ_OE |=> BURST_END && !DQ_OE)
    else $error("select high did not end the burst");
  AST_IDLE_QUIET: assert property (CS_N && $past(CS_N)
    |-> !DQ_OE && !CMD_VALID && !WR_VALID && !ROW_VALID)
    else $error("activity while deselected");

  cover property (CMD_VALID && CMD_READ);
  cover property (WR_VALID && WR_BYTE_EN != 2'b11);
  cover property (START_ERROR);
  cover property (BURST_END);
endmodule // dca_decode_x16_asserts

bind dca_decode_x16 dca_decode_x16_asserts #(.RD_DEPTH(RD_DEPTH)) u_asserts (
  .MCLK(MCLK), .RESETN(RESETN), .CS_N(CS_N), .BUS_CLOCK_TRUE(BUS_CLOCK_TRUE),
  .BUS_CLOCK_COMPLEMENT(BUS_CLOCK_COMPLEMENT), .LATENCY_EXTRA(LATENCY_EXTRA),
  .ZERO_LATENCY_WRITE(ZERO_LATENCY_WRITE), .DQ_OE(DQ_OE),
  .RW_DATA_STROBE_OUT(RW_DATA_STROBE_OUT), .RW_DATA_STROBE_OE(RW_DATA_STROBE_OE),
  .START_ERROR(START_ERROR), .ROW_VALID(ROW_VALID), .ROW_ADDR(ROW_ADDR),
  .ROW_READ(ROW_READ), .CMD_VALID(CMD_VALID), .CMD_READ(CMD_READ),
  .CMD_WORD_ADDR(CMD_WORD_ADDR), .BURST_END(BURST_END), .WR_VALID(WR_VALID),
  .WR_BYTE_EN(WR_BYTE_EN)
);
`default_nettype wire

// ---- verification/dca_host.sv ----
// host memory controller model: select, bus clock, data lines, write masks
// assumes tasks are entered at a falling edge of mclk
`timescale 1ns/1ps
`default_nettype none

module dca_host (
  input  wire logic        mclk,
  output logic             cs_n,
  output logic             ck_t,
  output logic             ck_c,
  output logic      [15:0] dq,
  output logic      [1:0]  strb
);
  initial begin
    cs_n = 1'b1;
    ck_t = 1'b0;
    ck_c = 1'b1;
    dq   = 16'h0000;
    strb = 2'b00;
  end

  // bad=1 raises the bus clock first so the start must be refused
  task automatic start(input bit bad);
    @(negedge mclk);
    ck_t = bad;
    ck_c = ~bad;
    @(negedge mclk);
    cs_n = 1'b0;
    @(negedge mclk);
  endtask

  // data placed a cycle before the bus edge and held one after: centred
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    dq   = d;
    strb = m;
    @(negedge mclk);
    ck_t = ~ck_t;
    ck_c = ~ck_c;
    @(negedge mclk);
  endtask

  task automatic cmd(input logic [47:0] ca, input logic [7:0] hi);
    for (int i = 5; i >= 0; i--) begin
      beat({hi ^ 8'(i), ca[i*8 +: 8]}, 2'b00);
    end
  endtask

  // clock back to idle before select rises; released lines flip
  task automatic stop();
    repeat (3) @(negedge mclk);
    ck_t = 1'b0;
    ck_c = 1'b1;
    @(negedge mclk);
    cs_n = 1'b1;
    dq   = ~dq;
    strb = ~strb;
    repeat (2) @(negedge mclk);
  endtask
endmodule // dca_host
`default_nettype wire

// ---- verification/dca_decode_x16_tb.sv ----
// self-checking bench for the command/address decoder and data phase
// assumes the host model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module dca_decode_x16_tb;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        lat = 1'b0;
  logic        zlw = 1'b0;
  logic        dstart = 1'b0;
  logic [15:0] rd_data = 16'h0000;
  logic        rd_valid = 1'b0;
  wire         cs_n, ck_t, ck_c;
  wire  [15:0] hdq, dq_in, dq_out;
  wire  [1:0]  hstrb, strb_in, so, soe, wr_en;
  wire         dq_oe, start_err, cmd_valid, cmd_read, cmd_reg, cmd_lin;
  wire  [31:0] cmd_addr, beat_addr;
  wire         beat_sec, rd_ready, rd_under, wr_valid;
  wire  [15:0] wr_data;
  int          seed = 9077;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [47:0] q[$];
  logic [1:0]  last_so = 2'b00;
  logic [31:0] a;
  logic [15:0] d;
  logic [1:0]  m;
  logic [15:0] w [3];

  always #12.5 mclk = ~mclk;
  assign dq_in   = dq_oe ? dq_out : hdq;
  assign strb_in = (soe & so) | (~soe & hstrb);

  dca_host host (.mclk(mclk), .cs_n(cs_n), .ck_t(ck_t), .ck_c(ck_c), .dq(hdq), .strb(hstrb));

  dca_decode_x16 #(.RD_DEPTH(2)) DUT (
    .MCLK(mclk), .RESETN(resetn), .CS_N(cs_n), .BUS_CLOCK_TRUE(ck_t),
    .BUS_CLOCK_COMPLEMENT(ck_c), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
    .RW_DATA_STROBE_IN(strb_in), .RW_DATA_STROBE_OUT(so), .RW_DATA_STROBE_OE(soe),
    .LATENCY_EXTRA(lat), .ZERO_LATENCY_WRITE(zlw), .DATA_START(dstart),
    .START_ERROR(start_err), .ROW_VALID(), .ROW_ADDR(), .ROW_READ(), .CMD_VALID(cmd_valid),
    .CMD_READ(cmd_read), .CMD_REG_SPACE(cmd_reg), .CMD_LINEAR(cmd_lin),
    .CMD_WORD_ADDR(cmd_addr), .BURST_END(), .BEAT_ADDR(beat_addr), .BEAT_SECOND(beat_sec),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_UNDERRUN(rd_under),
    .WR_DATA(wr_data), .WR_BYTE_EN(wr_en), .WR_VALID(wr_valid)
  );

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic take(input logic [47:0] s, input string nm);
    logic [47:0] e;
    e = (q.size() > 0) ? q.pop_front() : 48'hx;
    `CHK(nm, e, s)
  endtask

  // results are matched in order against what the drivers noted
  always @(negedge mclk) begin
    if (start_err) take(48'h0, "start_error");
    if (cmd_valid) take({11'h0, 2'd1, cmd_read, cmd_reg, cmd_lin, cmd_addr}, "command");
    if (wr_valid) take({19'h0, 2'd2, wr_data, wr_en, beat_sec, beat_addr[7:0]}, "write");
    if (dq_oe && so !== last_so) take({27'h0, 2'd3, dq_out, so, rd_under}, "read");
    last_so = so;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic open(input logic [47:0] c);
    q.push_back({11'h0, 2'd1, c[47:16], c[2:0]});
    lat = 1'($random(seed));
    host.start(1'b0);
    host.cmd(c, 8'($random(seed)));
    repeat (3) @(negedge mclk);
  endtask

  task automatic go();
    dstart = 1'b1;
    @(negedge mclk);
    dstart = 1'b0;
    @(negedge mclk);
  endtask

  // holds valid until taken; the caller lowers it before the next edge
  task automatic push_rd(input logic [15:0] x);
    rd_data  = x;
    rd_valid = 1'b1;
    do @(posedge mclk); while (rd_ready !== 1'b1);
    @(negedge mclk);
  endtask

  initial begin
    repeat (8) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 8; i++) begin
      a = 32'($random(seed));
      open({3'(i), a[31:3], 13'h0000, a[2:0]});
      host.stop();
    end
    $display("test decode done");
    q.push_back(48'h0);
    host.start(1'b1);
    host.beat(16'h00a5, 2'b00);
    host.stop();
    host.start(1'b0);
    for (int i = 0; i < 3; i++) host.beat(16'h0000, 2'b00);
    host.stop();
    $display("test refusal and abort done");
    for (int z = 0; z < 2; z++) begin
      zlw = 1'(z);
      a = 32'($random(seed));
      open({3'b001, a[31:3], 13'h0000, a[2:0]});
      go();
      for (int k = 0; k < 4; k++) begin
        d = 16'($random(seed));
        m = z ? ~hstrb : 2'(k);
        q.push_back({19'h0, 2'd2, d, z ? 2'b11 : ~m, 1'(k % 2), 8'(a[7:0] + k / 2)});
        host.beat(d, m);
      end
      host.stop();
    end
    $display("test write done");
    zlw = 1'b0;
    a = 32'($random(seed));
    open({3'b101, a[31:3], 13'h0000, a[2:0]});
    go();
    for (int k = 0; k < 3; k++) w[k] = 16'($random(seed));
    push_rd(w[0]);
    push_rd(w[1]);
    fork
      begin
        // drop valid once taken, else the last word is pushed again
        push_rd(w[2]);
        rd_valid = 1'b0;
      end
      begin
        repeat (3) @(negedge mclk) `CHK("rd_ready", 1'b0, rd_ready)
        @(negedge mclk);
        for (int k = 0; k < 4; k++) begin
          q.push_back({27'h0, 2'd3, w[k < 3 ? k : 2], k % 2 ? 2'b00 : 2'b11, k == 3});
          host.beat(~hdq, hstrb);
        end
      end
    join
    rd_valid = 1'b0;
    host.stop();
    $display("test read done");
    repeat (4) @(negedge mclk);
    `CHK("pending results", 32'h0, 32'(q.size()))
    close_out();
  end
endmodule // dca_decode_x16_tb
`default_nettype wire
